// ### hw/pxd_map.svh
// Address map, field positions and timing constants of the proximity output delay block
// Notes on behaviour
// - Sensitivity switch selects normal or high sensitivity for the echo front end.
// - Mode switch selects object sensing or break-beam background sensing.
// - Polarity switch makes the switched output normally open or normally closed.
// - Delay-select switch picks whether the program button sets the ON or OFF delay.
// - Output goes active only after detection persists for the whole ON delay.
// - Output goes inactive only after detection stays absent for the whole OFF delay.
// - Button hold time with release select becomes the new OFF delay.
// - Button hold time with assert select becomes the new ON delay.
// - When the double-press window after release expires, the delay is written to nonvolatile storage and green flashes in the same cycle.
// - Two successive presses reset the selected delay to minimum, amber flashes.
`ifndef PXD_MAP_SVH
`define PXD_MAP_SVH

// Widths
`define PXD_DELAY_W       16
`define PXD_TICK_W        16
`define PXD_ADDR_W        4
`define PXD_DATA_W        32

// Register byte offsets
`define PXD_ADDR_STATUS   4'h0
`define PXD_ADDR_ON_DLY   4'h4
`define PXD_ADDR_OFF_DLY  4'h8

// Status field positions
`define PXD_ST_OUT_ACT    0
`define PXD_ST_DETECT     1
`define PXD_ST_SENS_HIGH  2
`define PXD_ST_BACKGROUND 3
`define PXD_ST_NC         4
`define PXD_ST_SEL_ON     5
`define PXD_ST_BUTTON     6
`define PXD_ST_READY      7

// Storage slots
`define PXD_SLOT_ON       1'b0
`define PXD_SLOT_OFF      1'b1

// Timing
`define PXD_CLK_NS        50
`define PXD_TICK_NS       1000000
`define PXD_FLASH_TICKS   16'h00fa
`define PXD_DOUBLE_TICKS  16'h01f4
`define PXD_MIN_DELAY     16'h0000
`define PXD_DELAY_MAX     16'hffff

`endif

// ### hw/pxd_pkg.sv
// Types of the proximity output delay block
`include "pxd_map.svh"

package pxd_pkg;

  typedef enum logic [3:0] {
    PXD_LOAD_ON      = 4'h0,
    PXD_LOAD_ON_WAIT = 4'h1,
    PXD_LOAD_ON_CAP  = 4'h2,
    PXD_LOAD_OFF     = 4'h3,
    PXD_LOAD_OFF_WT  = 4'h4,
    PXD_LOAD_OFF_CAP = 4'h5,
    PXD_IDLE         = 4'h6,
    PXD_HOLD         = 4'h7,
    PXD_GAP          = 4'h8,
    PXD_HOLD2        = 4'h9
  } pxd_state_e;

  typedef struct packed {
    logic detect;
    logic sens_high;
    logic background;
    logic nc;
    logic sel_on;
    logic button;
  } pxd_pins_s;

  typedef struct packed {
    pxd_state_e                  state;
    logic [`PXD_TICK_W-1:0]      tick_cnt;
    logic                        tick;
    logic [`PXD_DELAY_W-1:0]     on_dly;
    logic [`PXD_DELAY_W-1:0]     off_dly;
    logic [`PXD_DELAY_W-1:0]     run_cnt;
    logic                        out_act;
    logic [`PXD_DELAY_W-1:0]     hold_cnt;
    logic [`PXD_DELAY_W-1:0]     win_cnt;
    logic                        sel_on_cap;
    logic [`PXD_DELAY_W-1:0]     flash_cnt;
    logic                        flash_amber;
    logic                        led_green;
    logic                        led_amber;
    logic                        nvm_rd;
    logic                        nvm_we;
    logic                        nvm_addr;
    logic [`PXD_DELAY_W-1:0]     nvm_wdata;
    logic                        out_pin;
    logic                        sens_high;
    logic [`PXD_DATA_W-1:0]      rdata;
    logic                        btn_d;
    logic                        ready;
  } pxd_core_s;

endpackage : pxd_pkg

// ### hw/pxd_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pxd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [3:0][W-1:0] st_reg;
  logic [3:0][W-1:0] st_next;

  // Stage 1 feeds stage 2 only; output moves when stages 2 and 3 agree
  always_comb begin
    st_next    = st_reg;
    st_next[0] = d_i;
    st_next[1] = st_reg[0];
    st_next[2] = st_reg[1];
    for (int i = 0; i < W; i++) begin
      if (st_reg[1][i] == st_reg[2][i]) begin
        st_next[3][i] = st_reg[2][i];
      end
    end
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg[3];

endmodule : pxd_sync

`default_nettype wire

// ### hw/pxd_top.sv
// Switch configuration, programmable ON/OFF delay and storage sequencing of the proximity sensor
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "pxd_map.svh"

module pxd_top #(
  parameter int TICK_CYCLES = `PXD_TICK_NS / `PXD_CLK_NS
) (
  input  wire logic                    CLK_SYS_I,
  input  wire logic                    SYS_RST_I,
  input  wire logic                    DETECT_I,
  input  wire logic                    SW_SENS_HIGH_I,
  input  wire logic                    SW_BACKGROUND_I,
  input  wire logic                    SW_NC_I,
  input  wire logic                    SW_SEL_ON_I,
  input  wire logic                    BUTTON_I,
  input  wire logic [`PXD_DELAY_W-1:0] NVM_RDATA_I,
  input  wire logic [`PXD_ADDR_W-1:0]  REG_ADDR_I,
  input  wire logic [`PXD_DATA_W-1:0]  REG_WDATA_I,
  input  wire logic                    REG_WR_I,
  input  wire logic                    REG_RD_I,
  output logic                         OUTPUT_O,
  output logic                         SENS_HIGH_O,
  output logic                         LED_GREEN_O,
  output logic                         LED_AMBER_O,
  output logic                         NVM_RD_O,
  output logic                         NVM_WE_O,
  output logic                         NVM_ADDR_O,
  output logic [`PXD_DELAY_W-1:0]      NVM_WDATA_O,
  output logic [`PXD_DATA_W-1:0]       REG_RDATA_O
);

  localparam logic [`PXD_TICK_W-1:0] TICK_LAST = `PXD_TICK_W'(TICK_CYCLES - 1);

  pxd_pkg::pxd_core_s cur_reg;
  pxd_pkg::pxd_core_s cur_next;
  pxd_pkg::pxd_pins_s pins_raw;
  pxd_pkg::pxd_pins_s pins;

  // All pins come from outside the clock domain
  assign pins_raw = '{
    detect:     DETECT_I,
    sens_high:  SW_SENS_HIGH_I,
    background: SW_BACKGROUND_I,
    nc:         SW_NC_I,
    sel_on:     SW_SEL_ON_I,
    button:     BUTTON_I
  };

  pxd_sync #(
    .W ($bits(pxd_pkg::pxd_pins_s))
  ) u_sync (
    .clk_i (CLK_SYS_I),
    .rst_i (SYS_RST_I),
    .d_i   (pins_raw),
    .q_o   (pins)
  );

  // Next-state logic of the whole block
  always_comb begin
    logic                    press;
    logic                    release_ev;
    logic                    det;
    logic [`PXD_DELAY_W-1:0] target;
    logic                    commit;
    logic [`PXD_DELAY_W-1:0] commit_val;
    logic                    commit_amber;
    logic [`PXD_DATA_W-1:0]  status;

    press        = 1'b0;
    release_ev   = 1'b0;
    det          = 1'b0;
    target       = '0;
    commit       = 1'b0;
    commit_val   = '0;
    commit_amber = 1'b0;
    status       = '0;

    cur_next        = cur_reg;
    cur_next.nvm_rd = 1'b0;
    cur_next.nvm_we = 1'b0;
    cur_next.rdata  = '0;

    // Tick divider for delay and hold timing
    cur_next.tick = 1'b0;
    if (cur_reg.tick_cnt == TICK_LAST) begin
      cur_next.tick_cnt = '0;
      cur_next.tick     = 1'b1;
    end else begin
      cur_next.tick_cnt = cur_reg.tick_cnt + 1'b1;
    end

    // Button edges
    press          = pins.button & ~cur_reg.btn_d;
    release_ev     = ~pins.button & cur_reg.btn_d;
    cur_next.btn_d = pins.button;

    // Background mode: detection is loss of the background echo
    det = pins.detect ^ pins.background;

    // Sensitivity selection passed to the front end
    cur_next.sens_high = pins.sens_high;

    // Delay engine, runs once stored delays are loaded
    if (cur_reg.ready) begin
      if (det == cur_reg.out_act) begin
        cur_next.run_cnt = '0;
      end else begin
        target = cur_reg.out_act ? cur_reg.off_dly : cur_reg.on_dly;
        if (cur_reg.run_cnt >= target) begin
          cur_next.out_act = det;
          cur_next.run_cnt = '0;
        end else if (cur_reg.tick) begin
          cur_next.run_cnt = cur_reg.run_cnt + 1'b1;
        end
      end
    end

    // Output polarity
    cur_next.out_pin = cur_next.out_act ^ pins.nc;

    // Acknowledge flash countdown
    if (cur_reg.tick && cur_reg.flash_cnt != '0) begin
      cur_next.flash_cnt = cur_reg.flash_cnt - 1'b1;
    end

    // Sequencer: storage load, then button programming
    case (cur_reg.state)
      pxd_pkg::PXD_LOAD_ON: begin
        cur_next.nvm_rd   = 1'b1;
        cur_next.nvm_addr = `PXD_SLOT_ON;
        cur_next.state    = pxd_pkg::PXD_LOAD_ON_WAIT;
      end
      pxd_pkg::PXD_LOAD_ON_WAIT: begin
        cur_next.state = pxd_pkg::PXD_LOAD_ON_CAP;
      end
      pxd_pkg::PXD_LOAD_ON_CAP: begin
        cur_next.on_dly = NVM_RDATA_I;
        cur_next.state  = pxd_pkg::PXD_LOAD_OFF;
      end
      pxd_pkg::PXD_LOAD_OFF: begin
        cur_next.nvm_rd   = 1'b1;
        cur_next.nvm_addr = `PXD_SLOT_OFF;
        cur_next.state    = pxd_pkg::PXD_LOAD_OFF_WT;
      end
      pxd_pkg::PXD_LOAD_OFF_WT: begin
        cur_next.state = pxd_pkg::PXD_LOAD_OFF_CAP;
      end
      pxd_pkg::PXD_LOAD_OFF_CAP: begin
        cur_next.off_dly = NVM_RDATA_I;
        cur_next.ready   = 1'b1;
        cur_next.state   = pxd_pkg::PXD_IDLE;
      end
      pxd_pkg::PXD_IDLE: begin
        if (press) begin
          cur_next.sel_on_cap = pins.sel_on;
          cur_next.hold_cnt   = '0;
          cur_next.state      = pxd_pkg::PXD_HOLD;
        end
      end
      pxd_pkg::PXD_HOLD: begin
        if (cur_reg.tick && cur_reg.hold_cnt != `PXD_DELAY_MAX) begin
          cur_next.hold_cnt = cur_reg.hold_cnt + 1'b1;
        end
        if (release_ev) begin
          cur_next.win_cnt = '0;
          cur_next.state   = pxd_pkg::PXD_GAP;
        end
      end
      pxd_pkg::PXD_GAP: begin
        if (press) begin
          cur_next.state = pxd_pkg::PXD_HOLD2;
        end else if (cur_reg.tick) begin
          if (cur_reg.win_cnt == `PXD_DOUBLE_TICKS - 1'b1) begin
            commit         = 1'b1;
            commit_val     = cur_reg.hold_cnt;
            cur_next.state = pxd_pkg::PXD_IDLE;
          end else begin
            cur_next.win_cnt = cur_reg.win_cnt + 1'b1;
          end
        end
      end
      pxd_pkg::PXD_HOLD2: begin
        if (release_ev) begin
          commit         = 1'b1;
          commit_val     = `PXD_MIN_DELAY;
          commit_amber   = 1'b1;
          cur_next.state = pxd_pkg::PXD_IDLE;
        end
      end
      default: begin
        cur_next.state = pxd_pkg::PXD_LOAD_ON;
      end
    endcase

    // Store a button-programmed delay and start its acknowledge
    if (commit) begin
      if (cur_reg.sel_on_cap) begin
        cur_next.on_dly = commit_val;
      end else begin
        cur_next.off_dly = commit_val;
      end
      cur_next.nvm_we      = 1'b1;
      cur_next.nvm_addr    = cur_reg.sel_on_cap ? `PXD_SLOT_ON : `PXD_SLOT_OFF;
      cur_next.nvm_wdata   = commit_val;
      cur_next.flash_cnt   = `PXD_FLASH_TICKS;
      cur_next.flash_amber = commit_amber;
    end

    // Software write of a delay, accepted only while the button sequencer idles
    if (REG_WR_I && cur_reg.state == pxd_pkg::PXD_IDLE && !press) begin
      case (REG_ADDR_I)
        `PXD_ADDR_ON_DLY: begin
          cur_next.on_dly    = REG_WDATA_I[`PXD_DELAY_W-1:0];
          cur_next.nvm_we    = 1'b1;
          cur_next.nvm_addr  = `PXD_SLOT_ON;
          cur_next.nvm_wdata = REG_WDATA_I[`PXD_DELAY_W-1:0];
        end
        `PXD_ADDR_OFF_DLY: begin
          cur_next.off_dly   = REG_WDATA_I[`PXD_DELAY_W-1:0];
          cur_next.nvm_we    = 1'b1;
          cur_next.nvm_addr  = `PXD_SLOT_OFF;
          cur_next.nvm_wdata = REG_WDATA_I[`PXD_DELAY_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // Indicator colours follow the flash countdown
    cur_next.led_green = (cur_next.flash_cnt != '0) & ~cur_next.flash_amber;
    cur_next.led_amber = (cur_next.flash_cnt != '0) & cur_next.flash_amber;

    // Status word
    status[`PXD_ST_OUT_ACT]    = cur_reg.out_act;
    status[`PXD_ST_DETECT]     = det;
    status[`PXD_ST_SENS_HIGH]  = pins.sens_high;
    status[`PXD_ST_BACKGROUND] = pins.background;
    status[`PXD_ST_NC]         = pins.nc;
    status[`PXD_ST_SEL_ON]     = pins.sel_on;
    status[`PXD_ST_BUTTON]     = pins.button;
    status[`PXD_ST_READY]      = cur_reg.ready;

    // Read data, valid in the cycle after the strobe
    if (REG_RD_I) begin
      case (REG_ADDR_I)
        `PXD_ADDR_STATUS:  cur_next.rdata = status;
        `PXD_ADDR_ON_DLY:  cur_next.rdata = {{(`PXD_DATA_W-`PXD_DELAY_W){1'b0}}, cur_reg.on_dly};
        `PXD_ADDR_OFF_DLY: cur_next.rdata = {{(`PXD_DATA_W-`PXD_DELAY_W){1'b0}}, cur_reg.off_dly};
        default:           cur_next.rdata = '0;
      endcase
    end
  end

  // State register
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      cur_reg       <= '0;
      cur_reg.state <= pxd_pkg::PXD_LOAD_ON;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Outputs straight from the state register
  assign OUTPUT_O    = cur_reg.out_pin;
  assign SENS_HIGH_O = cur_reg.sens_high;
  assign LED_GREEN_O = cur_reg.led_green;
  assign LED_AMBER_O = cur_reg.led_amber;
  assign NVM_RD_O    = cur_reg.nvm_rd;
  assign NVM_WE_O    = cur_reg.nvm_we;
  assign NVM_ADDR_O  = cur_reg.nvm_addr;
  assign NVM_WDATA_O = cur_reg.nvm_wdata;
  assign REG_RDATA_O = cur_reg.rdata;

endmodule : pxd_top

`default_nettype wire

// ### tb/pxd_nvm_model.sv
// Storage model holding the two programmed delays
`timescale 1ns/1ps
`default_nettype none
`include "pxd_map.svh"

module pxd_nvm_model #(
  parameter logic [`PXD_DELAY_W-1:0] ON_INIT  = 16'h0003,
  parameter logic [`PXD_DELAY_W-1:0] OFF_INIT = 16'h0005
) (
  input  wire logic                    clk_i,
  input  wire logic                    rd_i,
  input  wire logic                    we_i,
  input  wire logic                    addr_i,
  input  wire logic [`PXD_DELAY_W-1:0] wdata_i,
  output logic      [`PXD_DELAY_W-1:0] rdata_o
);
  logic [`PXD_DELAY_W-1:0] mem [2] = '{ON_INIT, OFF_INIT};

  // Write on the pulse; data valid only in the cycle after a read pulse, junk otherwise
  always @(posedge clk_i) begin
    if (we_i) mem[addr_i] <= wdata_i;
    rdata_o <= rd_i ? mem[addr_i] : ~rdata_o;
  end
endmodule : pxd_nvm_model
`default_nettype wire

// ### tb/pxd_top_asserts.sv
// Port-level checks of the proximity output delay block
`timescale 1ns/1ps
`default_nettype none
`include "pxd_map.svh"

module pxd_top_asserts #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic                    CLK_SYS_I,
  input wire logic                    SYS_RST_I,
  input wire logic                    DETECT_I,
  input wire logic                    SW_SENS_HIGH_I,
  input wire logic                    SW_BACKGROUND_I,
  input wire logic                    SW_NC_I,
  input wire logic                    OUTPUT_O,
  input wire logic                    SENS_HIGH_O,
  input wire logic                    LED_GREEN_O,
  input wire logic                    LED_AMBER_O,
  input wire logic                    NVM_RD_O,
  input wire logic                    NVM_WE_O,
  input wire logic                    NVM_ADDR_O,
  input wire logic [`PXD_DELAY_W-1:0] NVM_WDATA_O
);
  logic [2:0] sw_q;
  logic [3:0] sens_cnt;
  logic [3:0] cfg_cnt;

  // Cycles since the sensitivity and the mode/polarity switches last moved
  always_ff @(posedge CLK_SYS_I) begin
    sw_q     <= {SW_SENS_HIGH_I, SW_NC_I, SW_BACKGROUND_I};
    sens_cnt <= (SYS_RST_I || sw_q[2] != SW_SENS_HIGH_I) ? 4'h0 : sens_cnt + {3'h0, sens_cnt != 4'hf};
    cfg_cnt  <= (SYS_RST_I || sw_q[1:0] != {SW_NC_I, SW_BACKGROUND_I}) ? 4'h0 : cfg_cnt + {3'h0, cfg_cnt != 4'hf};
  end

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  // Counters lag a switch move by one edge, so the move itself is excluded
  property p_sens; sens_cnt >= 4'h8 && $stable(SW_SENS_HIGH_I) |-> SENS_HIGH_O == SW_SENS_HIGH_I; endproperty
  a_sens: assert property (p_sens) else $error("sensitivity output off switch");
  property p_on;
    $rose(OUTPUT_O ^ SW_NC_I) && cfg_cnt >= 4'h8 && $stable({SW_NC_I, SW_BACKGROUND_I})
      |-> $past(DETECT_I ^ SW_BACKGROUND_I, 2);
  endproperty
  a_on: assert property (p_on) else $error("output active without detection");
  property p_off;
    $fell(OUTPUT_O ^ SW_NC_I) && cfg_cnt >= 4'h8 && $stable({SW_NC_I, SW_BACKGROUND_I})
      |-> !$past(DETECT_I ^ SW_BACKGROUND_I, 2);
  endproperty
  a_off: assert property (p_off) else $error("output inactive while detecting");
  property p_load; $fell(SYS_RST_I) |-> ##[1:2] (NVM_RD_O && !NVM_ADDR_O) ##3 (NVM_RD_O && NVM_ADDR_O); endproperty
  a_load: assert property (p_load) else $error("delays not loaded after reset");
  property p_rd_pulse; NVM_RD_O |=> !NVM_RD_O; endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("storage read not a pulse");
  property p_we_pulse; NVM_WE_O |=> !NVM_WE_O; endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("storage write not a pulse");
  property p_green_we; $rose(LED_GREEN_O) |-> NVM_WE_O; endproperty
  a_green_we: assert property (p_green_we) else $error("green flash without storage write");
  property p_green_hold; $rose(LED_GREEN_O) |=> LED_GREEN_O [*8]; endproperty
  a_green_hold: assert property (p_green_hold) else $error("green flash too short");
  property p_amber_zero; $rose(LED_AMBER_O) |-> NVM_WE_O && NVM_WDATA_O == `PXD_MIN_DELAY; endproperty
  a_amber_zero: assert property (p_amber_zero) else $error("amber flash without minimum write");
  property p_led_excl; !(LED_GREEN_O && LED_AMBER_O); endproperty
  a_led_excl: assert property (p_led_excl) else $error("green and amber together");

  c_green: cover property ($rose(LED_GREEN_O));
  c_amber: cover property ($rose(LED_AMBER_O));
  c_out:   cover property ($rose(OUTPUT_O) && cfg_cnt >= 4'h8);
endmodule : pxd_top_asserts
`default_nettype wire

// ### tb/pxd_top_tb.sv
// Self-checking bench of the proximity output delay block
`timescale 1ns/1ps
`default_nettype none
`include "pxd_map.svh"

module pxd_top_tb;
  localparam int TICK_CYCLES = 4;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    det = 1'b0, sens = 1'b0, bg = 1'b0, nc = 1'b0, sel = 1'b0, btn = 1'b0;
  logic                    wr = 1'b0, rd = 1'b0;
  logic [`PXD_ADDR_W-1:0]  addr = 4'h0;
  logic [`PXD_DATA_W-1:0]  wdata = 32'h0, rdata;
  logic                    out, sens_o, grn, amb, nvm_rd, nvm_we, nvm_a;
  logic [`PXD_DELAY_W-1:0] nvm_wd, nvm_rdat;
  int                      num_errors = 0, n_tests = 0;

  initial forever #25 clk = ~clk;

  pxd_top #(.TICK_CYCLES(TICK_CYCLES)) dut (
    .CLK_SYS_I(clk), .SYS_RST_I(rst), .DETECT_I(det), .SW_SENS_HIGH_I(sens), .SW_BACKGROUND_I(bg),
    .SW_NC_I(nc), .SW_SEL_ON_I(sel), .BUTTON_I(btn), .NVM_RDATA_I(nvm_rdat), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .OUTPUT_O(out), .SENS_HIGH_O(sens_o),
    .LED_GREEN_O(grn), .LED_AMBER_O(amb), .NVM_RD_O(nvm_rd), .NVM_WE_O(nvm_we), .NVM_ADDR_O(nvm_a),
    .NVM_WDATA_O(nvm_wd), .REG_RDATA_O(rdata));

  pxd_nvm_model u_nvm (.clk_i(clk), .rd_i(nvm_rd), .we_i(nvm_we), .addr_i(nvm_a), .wdata_i(nvm_wd),
    .rdata_o(nvm_rdat));

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic pins(input logic d, input logic b, input logic n, input logic s);
    @(posedge clk);
    det  <= d;
    bg   <= b;
    nc   <= n;
    sens <= s;
  endtask : pins

  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    d = rdata;
  endtask : reg_rd

  // Operator sets the select switch, then holds the button n cycles
  task automatic press(input logic s, input int n);
    @(posedge clk);
    sel <= s;
    repeat (8) @(posedge clk);
    btn <= 1'b1;
    repeat (n) @(posedge clk);
    btn <= 1'b0;
  endtask : press

  task automatic wait_led(input logic g, input string what);
    int i;
    for (i = 0; i < 3000 && (g ? grn : amb) !== 1'b1; i++) cyc(1);
    chk(what, g ? grn : amb, 1'b1);
    for (i = 0; i < 1200 && (grn | amb) !== 1'b0; i++) cyc(1);
  endtask : wait_led

  task automatic give_verdict;
    $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // Watchdog for a hung sequence
  initial begin
    #2000000;
    num_errors++;
    give_verdict();
  end

  // Main sequence
  initial begin
    logic [31:0] v;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cyc(20);
    reg_rd(`PXD_ADDR_ON_DLY, v);
    chk("on delay loaded", v, 32'h3);
    reg_rd(`PXD_ADDR_OFF_DLY, v);
    chk("off delay loaded", v, 32'h5);
    reg_rd(4'hc, v);
    chk("unmapped read", v, 32'h0);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(6); // Burst shorter than ON delay less one tick
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    cyc(8);
    pins(1'b1, 1'b0, 1'b0, 1'b0);
    cyc(8);
    chk("out after restart", out, 1'b0);
    cyc(24);
    chk("out after on delay", out, 1'b1);
    pins(1'b0, 1'b0, 1'b0, 1'b0);
    cyc(12);
    chk("out held after loss", out, 1'b1);
    cyc(28);
    chk("out after off delay", out, 1'b0);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    cyc(8);
    chk("inactive closed", out, 1'b1);
    pins(1'b0, 1'b1, 1'b0, 1'b0);
    cyc(40);
    chk("background active", out, 1'b1);
    reg_rd(`PXD_ADDR_STATUS, v);
    chk("status", v, 32'h8b);
    pins(1'b0, 1'b0, 1'b0, 1'b1);
    cyc(40);
    chk("background clear", out, 1'b0);
    chk("sensitivity out", sens_o, 1'b1);
    reg_rd(`PXD_ADDR_STATUS, v);
    chk("status sens", v[`PXD_ST_SENS_HIGH], 1'b1);
    reg_wr(`PXD_ADDR_ON_DLY, 32'hffff_0002);
    reg_rd(`PXD_ADDR_ON_DLY, v);
    chk("on delay written", v, 32'h2);
    chk("on delay stored", u_nvm.mem[0], 16'h0002);
    press(1'b0, 40);
    wait_led(1'b1, "green off");
    reg_rd(`PXD_ADDR_OFF_DLY, v);
    chk("off from hold", v >= 32'h9 && v <= 32'hb, 1'b1);
    chk("off stored", u_nvm.mem[1], v[15:0]);
    reg_rd(`PXD_ADDR_ON_DLY, v);
    chk("on untouched", v, 32'h2);
    reg_wr(`PXD_ADDR_OFF_DLY, 32'h0000_0007);
    reg_rd(`PXD_ADDR_OFF_DLY, v);
    chk("off delay written", v, 32'h7);
    chk("off delay stored", u_nvm.mem[1], 16'h0007);
    press(1'b1, 20);
    wait_led(1'b1, "green on");
    reg_rd(`PXD_ADDR_ON_DLY, v);
    chk("on from hold", v >= 32'h4 && v <= 32'h6, 1'b1);
    chk("on stored", u_nvm.mem[0], v[15:0]);
    press(1'b1, 20);
    cyc(20);
    press(1'b1, 20);
    wait_led(1'b0, "amber");
    reg_rd(`PXD_ADDR_ON_DLY, v);
    chk("on reset", v, 32'h0);
    chk("on reset stored", u_nvm.mem[0], `PXD_MIN_DELAY);
    give_verdict();
  end
endmodule : pxd_top_tb

bind pxd_top pxd_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLK_SYS_I, .SYS_RST_I, .DETECT_I, .SW_SENS_HIGH_I, .SW_BACKGROUND_I, .SW_NC_I, .OUTPUT_O, .SENS_HIGH_O,
  .LED_GREEN_O, .LED_AMBER_O, .NVM_RD_O, .NVM_WE_O, .NVM_ADDR_O, .NVM_WDATA_O);
`default_nettype wire
